// File: rtl/acop_pkg.sv
// package: constants and types for the converter clock and output path
package acop_pkg;
  localparam int unsigned ACOP_DATA_W = 14;
  localparam int unsigned ACOP_LATENCY = 10;
  localparam int unsigned ACOP_DIV_MIN = 1;
  localparam int unsigned ACOP_DIV_MAX = 8;
  localparam int unsigned ACOP_FIFO_DEPTH = 8;
  localparam logic [2:0] ACOP_DIV_RST = 3'h0;
  localparam logic [2:0] ACOP_DIV_CNT_INIT = 3'h0;
  localparam logic [13:0] ACOP_OB_NEG_FS = 14'h0000;
  localparam logic [13:0] ACOP_OB_ZERO = 14'h2000;
  localparam logic [13:0] ACOP_OB_POS_FS = 14'h3FFF;
  localparam logic [13:0] ACOP_TC_NEG_FS = 14'h2000;
  localparam logic [13:0] ACOP_TC_POS_FS = 14'h1FFF;
  localparam int unsigned ACOP_CLK_MHZ = 250;
  localparam int unsigned ACOP_DCS_MIN_MHZ = 40;
  localparam int unsigned ACOP_DCS_LOCK_NS = 1500;
  localparam int unsigned ACOP_DCS_LOCK_CYC = (ACOP_DCS_LOCK_NS * ACOP_CLK_MHZ + 999) / 1000;
  localparam logic ACOP_DCS_EN_RST = 1'b1;
  typedef enum logic [1:0] {
    ACOP_FMT_OFFSET = 2'h0,
    ACOP_FMT_TWOS = 2'h1,
    ACOP_FMT_GRAY = 2'h2
  } acop_fmt_type;
  localparam acop_fmt_type ACOP_FMT_RST = ACOP_FMT_TWOS;
  typedef enum logic [2:0] {
    ACOP_PWR_RUN = 3'h1,
    ACOP_PWR_STBY = 3'h2,
    ACOP_PWR_DOWN = 3'h4
  } acop_pwr_type;
endpackage

// File: rtl/acop_fifo.sv
// fifo: parameterised flip-flop buffer with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module acop_fifo #(
  parameter int unsigned WIDTH = 30,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rd_reg];

  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_reg] = in_data_i;
      wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// File: rtl/acop_top.sv
// top: divider, stabilizer control, power modes, coding, latency and output path
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - sample clock divider ratio programmable from 1 to 8.
// - stabilizer enabled out of reset with no configuration.
// - two bits pick realign on every align pulse or first only.
// - accepted align pulse returns divider to its initial count.
// - locked, enabled stabilizer gives nominal half-period high time.
// - stabilizer loop need not run below forty megahertz.
// - unlocked stabilizer is bypassed; timing follows raw duty.
// - power-down when pin high or configuration bit set.
// - output drivers high impedance during power-down.
// - pin low (and bit clear) returns to normal conversion.
// - standby keeps reference powered for faster wake-up.
// - coding selectable: offset binary, twos complement, gray.
// - output disable pin high three-states data drivers.
// - per-channel disable bit three-states that channel only; the code three-states the drivers only when both bits are set.
// - one channel disabled: other channel fills both slots.
// - result appears ten sample clocks after its sampling edge.
// - overrange flag rides ten clocks later with its data.
// - offset binary codes zero, mid and all ones.
// - twos complement is default; mid, zero and 1FFF codes.
// - out-of-range inputs clamp to full scale and set flag.
// - data capture clock driven alongside the data.
// - analog input sampled on internal sample clock rising edge.
// - each result is a fourteen-bit corrected word.
module acop_top
  import acop_pkg::*;
#(
  parameter int unsigned DATA_W = ACOP_DATA_W,
  parameter int unsigned LATENCY = ACOP_LATENCY,
  parameter int unsigned FIFO_DEPTH = ACOP_FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // pins
  input wire logic power_down_pin_i,
  input wire logic output_disable_pin_i,
  input wire logic divider_align_input_i,
  // configuration
  input wire logic [2:0] div_ratio_m1_i,
  input wire logic align_every_i,
  input wire logic align_once_i,
  input wire logic align_cfg_wr_i,
  input wire logic dcs_disable_i,
  input wire logic dcs_rate_ok_i,
  input wire logic rate_change_i,
  input wire logic cfg_power_down_i,
  input wire logic cfg_standby_i,
  input wire logic [1:0] out_format_i,
  input wire logic [1:0] chan_disable_i,
  // converter core samples
  input wire logic [DATA_W-1:0] core_a_i,
  input wire logic [DATA_W-1:0] core_b_i,
  input wire logic [1:0] core_over_i,
  input wire logic [1:0] core_under_i,
  // capture side
  input wire logic cap_ready_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_n_o,
  output logic overrange_flag_o,
  output logic data_capture_clock_out_o,
  output logic sample_strobe_o,
  output logic dcs_locked_o,
  output logic dcs_active_o,
  output logic ref_powered_o,
  output logic [2:0] pwr_state_o
);
  localparam int unsigned SLOT_W = 2 * DATA_W + 2;
  localparam logic [15:0] LOCK_CYC = 16'(ACOP_DCS_LOCK_CYC);

  // pin synchronisers
  logic [2:0] pd_sync_reg, oe_sync_reg, al_sync_reg;
  logic pd_lvl_reg, oe_lvl_reg, al_lvl_reg, al_prev_reg;
  logic pd_lvl_next, oe_lvl_next, al_lvl_next;
  logic al_pulse;

  always_comb begin
    pd_lvl_next = (pd_sync_reg[1] == pd_sync_reg[2]) ? pd_sync_reg[2] : pd_lvl_reg;
    oe_lvl_next = (oe_sync_reg[1] == oe_sync_reg[2]) ? oe_sync_reg[2] : oe_lvl_reg;
    al_lvl_next = (al_sync_reg[1] == al_sync_reg[2]) ? al_sync_reg[2] : al_lvl_reg;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pd_sync_reg <= 3'h0;
      oe_sync_reg <= 3'h7;
      al_sync_reg <= 3'h0;
      pd_lvl_reg <= 1'b0;
      oe_lvl_reg <= 1'b1;
      al_lvl_reg <= 1'b0;
      al_prev_reg <= 1'b0;
    end else begin
      pd_sync_reg <= {pd_sync_reg[1:0], power_down_pin_i};
      oe_sync_reg <= {oe_sync_reg[1:0], output_disable_pin_i};
      al_sync_reg <= {al_sync_reg[1:0], divider_align_input_i};
      pd_lvl_reg <= pd_lvl_next;
      oe_lvl_reg <= oe_lvl_next;
      al_lvl_reg <= al_lvl_next;
      al_prev_reg <= al_lvl_reg;
    end
  end
  assign al_pulse = al_lvl_reg && !al_prev_reg;

  // clock divider and realignment
  logic [2:0] div_cnt_reg, div_cnt_next;
  logic armed_reg, armed_next;
  logic tick_reg, tick_next;
  logic align_ok;

  always_comb begin
    align_ok = al_pulse && (align_every_i || (align_once_i && armed_reg));
    armed_next = armed_reg;
    if (align_cfg_wr_i) begin
      armed_next = 1'b1;
    end else if (align_ok) begin
      armed_next = 1'b0;
    end
    tick_next = 1'b0;
    if (align_ok) begin
      div_cnt_next = ACOP_DIV_CNT_INIT;
    end else if (div_cnt_reg >= div_ratio_m1_i) begin
      div_cnt_next = ACOP_DIV_CNT_INIT;
      tick_next = 1'b1;
    end else begin
      div_cnt_next = div_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt_reg <= ACOP_DIV_RST;
      armed_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      armed_reg <= armed_next;
      tick_reg <= tick_next;
    end
  end

  // duty cycle stabilizer control
  logic dcs_en_reg, dcs_en_next;
  logic dcs_lock_reg, dcs_lock_next, act_reg, act_next;
  logic [15:0] lock_cnt_reg, lock_cnt_next;

  always_comb begin
    dcs_en_next = !dcs_disable_i;
    dcs_lock_next = dcs_lock_reg;
    lock_cnt_next = lock_cnt_reg;
    if (!dcs_en_reg || !dcs_rate_ok_i || rate_change_i) begin
      dcs_lock_next = 1'b0;
      lock_cnt_next = 16'h0000;
    end else if (!dcs_lock_reg) begin
      if (lock_cnt_reg >= LOCK_CYC - 16'h0001) begin
        dcs_lock_next = 1'b1;
      end else begin
        lock_cnt_next = lock_cnt_reg + 16'h0001;
      end
    end
    act_next = dcs_en_next && dcs_lock_next;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dcs_en_reg <= ACOP_DCS_EN_RST;
      dcs_lock_reg <= 1'b0;
      lock_cnt_reg <= 16'h0000;
      act_reg <= 1'b0;
    end else begin
      dcs_en_reg <= dcs_en_next;
      dcs_lock_reg <= dcs_lock_next;
      lock_cnt_reg <= lock_cnt_next;
      act_reg <= act_next;
    end
  end

  // power mode
  acop_pwr_type pwr_reg, pwr_next;
  logic refp_reg, refp_next;
  always_comb begin
    if (pd_lvl_reg || cfg_power_down_i) begin
      pwr_next = ACOP_PWR_DOWN;
    end else if (cfg_standby_i) begin
      pwr_next = ACOP_PWR_STBY;
    end else begin
      pwr_next = ACOP_PWR_RUN;
    end
    refp_next = (pwr_next != ACOP_PWR_DOWN);
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwr_reg <= ACOP_PWR_RUN;
      refp_reg <= 1'b1;
    end else begin
      pwr_reg <= pwr_next;
      refp_reg <= refp_next;
    end
  end

  // coding, clamping and latency pipe
  function automatic logic [DATA_W-1:0] code_word(input logic [DATA_W-1:0] tc,
                                                  input logic ov, input logic un,
                                                  input logic [1:0] fmt);
    logic [DATA_W-1:0] t;
    logic [DATA_W-1:0] ob;
    t = ov ? ACOP_TC_POS_FS : (un ? ACOP_TC_NEG_FS : tc);
    ob = {~t[DATA_W-1], t[DATA_W-2:0]};
    case (fmt)
      ACOP_FMT_OFFSET: code_word = ob;
      ACOP_FMT_GRAY: code_word = ob ^ (ob >> 1);
      default: code_word = t;
    endcase
  endfunction

  logic [SLOT_W-1:0] pipe_reg [LATENCY];
  logic [SLOT_W-1:0] pipe_next [LATENCY];
  logic [LATENCY-1:0] pv_reg, pv_next;
  logic run;

  always_comb begin
    run = (pwr_reg == ACOP_PWR_RUN);
    pipe_next = pipe_reg;
    pv_next = pv_reg;
    if (tick_reg) begin
      pipe_next[0] = {core_over_i[1] | core_under_i[1],
                      code_word(core_b_i, core_over_i[1], core_under_i[1], out_format_i),
                      core_over_i[0] | core_under_i[0],
                      code_word(core_a_i, core_over_i[0], core_under_i[0], out_format_i)};
      pv_next[0] = run;
      for (int i = 1; i < LATENCY; i++) begin
        pipe_next[i] = pipe_reg[i-1];
        pv_next[i] = pv_reg[i-1];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_reg[i] <= '0;
      end
      pv_reg <= '0;
    end else begin
      pipe_reg <= pipe_next;
      pv_reg <= pv_next;
    end
  end

  // output buffer
  logic fifo_in_ready, fifo_out_valid;
  logic [SLOT_W-1:0] fifo_out_data;
  logic push;
  assign push = tick_reg && pv_reg[LATENCY-1] && fifo_in_ready;

  acop_fifo #(
    .WIDTH(SLOT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(push),
    .in_data_i(pipe_reg[LATENCY-1]),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(cap_ready_i)
  );

  // interleaved output: slot 0 on capture clock high, slot 1 low
  logic half_reg, half_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic or_reg, or_next, dco_reg, dco_next, oen_reg, oen_next, stb_reg, stb_next;
  logic sel_b;

  always_comb begin
    half_next = half_reg;
    dout_next = dout_reg;
    or_next = or_reg;
    dco_next = dco_reg;
    stb_next = 1'b0;
    oen_next = oe_lvl_reg || (pwr_reg == ACOP_PWR_DOWN) || (&chan_disable_i);
    sel_b = half_reg ? !chan_disable_i[1] : chan_disable_i[0];
    if (fifo_out_valid && cap_ready_i) begin
      half_next = !half_reg;
      dco_next = !half_reg;
      stb_next = !half_reg;
      if (sel_b) begin
        dout_next = fifo_out_data[2*DATA_W:DATA_W+1];
        or_next = fifo_out_data[SLOT_W-1];
      end else begin
        dout_next = fifo_out_data[DATA_W-1:0];
        or_next = fifo_out_data[DATA_W];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      half_reg <= 1'b0;
      dout_reg <= '0;
      or_reg <= 1'b0;
      dco_reg <= 1'b0;
      oen_reg <= 1'b1;
      stb_reg <= 1'b0;
    end else begin
      half_reg <= half_next;
      dout_reg <= dout_next;
      or_reg <= or_next;
      dco_reg <= dco_next;
      oen_reg <= oen_next;
      stb_reg <= stb_next;
    end
  end

  assign data_o = dout_reg;
  assign data_oe_n_o = oen_reg;
  assign overrange_flag_o = or_reg;
  assign data_capture_clock_out_o = dco_reg;
  assign sample_strobe_o = stb_reg;
  assign dcs_locked_o = dcs_lock_reg;
  assign dcs_active_o = act_reg;
  assign ref_powered_o = refp_reg;
  assign pwr_state_o = pwr_reg;

  // checks
  a_div_period: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (tick_reg && div_ratio_m1_i != 3'h0) |=> !tick_reg)
    else $error("divider ticked early");
  a_div_range: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    div_cnt_reg <= $past(div_ratio_m1_i))
    else $error("divider count out of range");
  a_align_reset: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    align_ok |=> div_cnt_reg == ACOP_DIV_CNT_INIT && !tick_reg)
    else $error("align did not reset divider");
  a_once_disarm: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (align_ok && !align_every_i && !align_cfg_wr_i) |=> !armed_reg)
    else $error("single align did not disarm");
  a_lock_drop: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (!dcs_rate_ok_i || rate_change_i) |=> !dcs_lock_reg)
    else $error("stabilizer stayed locked");
  a_pd_hiz: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    pwr_reg == ACOP_PWR_DOWN |=> data_oe_n_o)
    else $error("drivers on in power-down");
  a_pd_enter: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    cfg_power_down_i |=> pwr_reg == ACOP_PWR_DOWN)
    else $error("power-down not entered");
  a_oe_pin: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    oe_lvl_reg |=> data_oe_n_o)
    else $error("drivers on while disable pin high");
  a_clamp_high: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (tick_reg && core_over_i[0]) |=> pipe_reg[0][DATA_W]
      && (pipe_reg[0][DATA_W-1:0] == code_word(ACOP_TC_POS_FS, 1'b0, 1'b0, $past(out_format_i))))
    else $error("overrange not clamped");
  c_align: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) align_ok);
  c_lock: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) $rose(dcs_lock_reg));
  c_out: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) stb_reg && or_reg);
  c_standby: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) pwr_reg == ACOP_PWR_STBY);
endmodule
`default_nettype wire

// File: bench/acop_cap_model.sv
// capture-side model: stalls the output path and registers slot A words
`timescale 1ns/1ns
`default_nettype none
module acop_cap_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // device outputs
  input wire logic [13:0] data_i,
  input wire logic data_oe_n_i,
  input wire logic dco_i,
  // stall control from the bench
  input wire logic hold_i,
  input wire logic stall_i,
  output logic cap_ready_o,
  output logic [13:0] word_a_o
);
  assign cap_ready_o = !hold_i && !stall_i;
  // registers the word of each capture clock high slot
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_a_o <= 14'h0000;
    end else if (!data_oe_n_i && dco_i) begin
      word_a_o <= data_i;
    end
  end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// testbench: drives the converter path and checks it against a coding model
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("Error %0t: got %h expected %h", $time, g, e); \
  end \
end
module tb_top;
  import acop_pkg::*;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic pd_pin = 1'b0, od_pin = 1'b0, align_pin = 1'b0, a_every = 1'b0, a_once = 1'b0;
  logic a_wr = 1'b0, dcs_off = 1'b0, rate_ok = 1'b1, rate_chg = 1'b0, cfg_pd = 1'b0;
  logic cfg_sb = 1'b0, hold = 1'b0, rnd = 1'b0, stall = 1'b0;
  logic [2:0] div_m1 = 3'h0;
  logic [1:0] fmt = 2'h1, ch_off = 2'h0, over = 2'h0, under = 2'h0;
  logic [13:0] core_a = 14'h0000, core_b = 14'h0000;
  logic cap_ready, data_oe_n, or_flag, data_capture_clock_out, locked, active, ref_on, stb;
  logic [13:0] data, word_a;
  logic [2:0] pwr;
  int fail_count = 0, tests_run = 0, n, v;
  int vals[4] = '{-8192, 0, 8191, 0};
  logic [31:0] seed = 32'h90F6;

  acop_top dut_u (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .power_down_pin_i(pd_pin),
    .output_disable_pin_i(od_pin), .divider_align_input_i(align_pin),
    .div_ratio_m1_i(div_m1), .align_every_i(a_every), .align_once_i(a_once),
    .align_cfg_wr_i(a_wr), .dcs_disable_i(dcs_off), .dcs_rate_ok_i(rate_ok),
    .rate_change_i(rate_chg), .cfg_power_down_i(cfg_pd), .cfg_standby_i(cfg_sb),
    .out_format_i(fmt), .chan_disable_i(ch_off), .core_a_i(core_a), .core_b_i(core_b),
    .core_over_i(over), .core_under_i(under), .cap_ready_i(cap_ready), .data_o(data),
    .data_oe_n_o(data_oe_n), .overrange_flag_o(or_flag), .data_capture_clock_out_o(data_capture_clock_out),
    .sample_strobe_o(stb), .dcs_locked_o(locked), .dcs_active_o(active),
    .ref_powered_o(ref_on), .pwr_state_o(pwr)
  );
  acop_cap_model cap_u (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .data_i(data), .data_oe_n_i(data_oe_n),
    .dco_i(data_capture_clock_out), .hold_i(hold), .stall_i(stall), .cap_ready_o(cap_ready),
    .word_a_o(word_a)
  );

  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  always @(negedge ref_clk_i) begin
    stall <= rnd && ($random(seed) % 2 != 0);
  end

  // reference coding of a twos complement core word
  function automatic logic [13:0] code(int x, int f, bit ov, bit un);
    int ob;
    if (ov) x = 8191;
    else if (un) x = -8192;
    ob = x + 8192;
    if (f == 0) return 14'(ob);
    if (f == 2) return 14'(ob ^ (ob >> 1));
    return 14'(x);
  endfunction

  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask
  task automatic give_up;
    fail_count++;
    $display("Error %0t: wait timed out", $time);
    end_sim;
  endtask
  task automatic wait_pwr(input logic [2:0] e);
    n = 0;
    while (pwr !== e && n <= 20) begin
      tick(1);
      n++;
    end
    `CHK(pwr, e)
    if (n > 20) give_up;
  endtask
  task automatic relock;
    n = 0;
    while (locked !== 1'b1) begin
      tick(1);
      n++;
      if (n > 1000) give_up;
    end
  endtask
  task automatic settle(input int a, input int b, input bit ov, input bit un, input int ev);
    logic [13:0] e;
    e = code(ev, fmt, ov, un);
    core_a = 14'(a);
    core_b = 14'(b);
    over = {2{ov}};
    under = {2{un}};
    tick(120);
    repeat (4) begin
      tick(1);
      `CHK(data, e)
      `CHK(or_flag, 1'(ov | un))
      `CHK(data_oe_n, 1'b0)
    end
    `CHK(word_a, e)
  endtask
  task automatic latency(input logic [2:0] m);
    logic [13:0] e;
    div_m1 = m;
    settle(5, 5, 0, 0, 5);
    core_a = 14'h0AAA;
    core_b = 14'h0AAA;
    e = code(2730, fmt, 0, 0);
    n = 0;
    while (data !== e) begin
      tick(1);
      n++;
      if (n > 200) give_up;
    end
    `CHK(n >= 10 * (m + 1) && n <= 11 * (m + 1) + 8, 1'b1)
  endtask
  // align pulse at ratio 8: taken one moves the next pop to 15 clocks after the pulse
  task automatic align_chk(input int k);
    logic d;
    align_pin = 1'b1;
    tick(2);
    align_pin = 1'b0;
    tick(5);
    d = data_capture_clock_out;
    n = 0;
    while (data_capture_clock_out === d && n <= 20) begin
      tick(1);
      n++;
    end
    `CHK(n, k)
    `CHK(stb, data_capture_clock_out)
    if (n > 20) give_up;
  endtask

  initial begin
    tick(12);
    nrst_i = 1'b1;
    `CHK(pwr, ACOP_PWR_RUN)
    relock;
    `CHK(n >= 370 && n <= 385, 1'b1)
    `CHK(active, 1'b1)
    rnd = 1'b1;
    for (int f = 0; f < 4; f++) begin
      fmt = 2'(f);
      vals[3] = $random(seed) % 8192;
      foreach (vals[i]) settle(vals[i], vals[i], 0, 0, vals[i]);
      settle(vals[3], vals[3], 1, 0, vals[3]);
      settle(vals[3], vals[3], 0, 1, vals[3]);
    end
    fmt = 2'h1;
    ch_off = 2'h2;
    settle(100, 200, 0, 0, 100);
    ch_off = 2'h1;
    settle(100, 200, 0, 0, 200);
    ch_off = 2'h3;
    tick(20);
    `CHK(data_oe_n, 1'b1)
    ch_off = 2'h0;
    hold = 1'b1;
    tick(60);
    hold = 1'b0;
    settle(77, 77, 0, 0, 77);
    rnd = 1'b0;
    latency(3'h0);
    latency(3'h3);
    a_every = 1'b1;
    latency(3'h7);
    align_chk(8);
    tick(3);
    align_chk(8);
    a_every = 1'b0;
    a_once = 1'b1;
    a_wr = 1'b1;
    tick(1);
    a_wr = 1'b0;
    align_chk(8);
    tick(3);
    align_chk(6);
    latency(3'h7);
    div_m1 = 3'h0;
    rate_chg = 1'b1;
    tick(1);
    rate_chg = 1'b0;
    tick(2);
    `CHK(locked, 1'b0)
    `CHK(active, 1'b0)
    relock;
    `CHK(n >= 365 && n <= 380, 1'b1)
    dcs_off = 1'b1;
    tick(4);
    `CHK(active, 1'b0)
    dcs_off = 1'b0;
    rate_ok = 1'b0;
    tick(4);
    `CHK(locked, 1'b0)
    rate_ok = 1'b1;
    relock;
    pd_pin = 1'b1;
    wait_pwr(ACOP_PWR_DOWN);
    tick(2);
    `CHK(data_oe_n, 1'b1)
    `CHK(ref_on, 1'b0)
    pd_pin = 1'b0;
    wait_pwr(ACOP_PWR_RUN);
    cfg_pd = 1'b1;
    wait_pwr(ACOP_PWR_DOWN);
    cfg_pd = 1'b0;
    cfg_sb = 1'b1;
    wait_pwr(ACOP_PWR_STBY);
    `CHK(ref_on, 1'b1)
    cfg_sb = 1'b0;
    wait_pwr(ACOP_PWR_RUN);
    od_pin = 1'b1;
    tick(8);
    `CHK(data_oe_n, 1'b1)
    od_pin = 1'b0;
    settle(-3, -3, 0, 0, -3);
    end_sim;
  end
endmodule
`default_nettype wire
